/* File: hw/rtcb_timekeeping.sv */
// Calendar and time-of-day counter bank with its serial port.
// Assumes a 100 MHz clock, a 32.768 kHz oscillator pin and a backup pin.
//
// How it works
// - Seconds tens digit is BCD 0-5.
// - Seconds units digit is BCD 0-9.
// - Invalid digits keep counting until field rollover.
// - Readback may lag one second after backup.
// - Four missed oscillator pulses latch the fail flag.
// - Fail flag set at power-up, host clears.
// - Minutes tens digit is BCD 0-5.
// - Minutes units digit is BCD 0-9.
// - Century bit maintained only when tracking enabled.
// - Century bit toggles on year 99 to 00.
// - Hours count 24-hour, tens digit 0-2.
// - Hours units digit is BCD 0-9.
// - Weekday counts 1 to 7 each day.
// - Weekday written as zero advances until rollover.
// - Date is BCD 01-31, host writes legal dates.
// - Month is BCD 01-12, host writes legal months.
// - Year is two BCD digits 0-9.
// - Halt bit stops oscillator, cleared at power-up, host sets and clears.
// - Backup mode refuses serial access to registers.
// - Slave only, address byte 11010000b/11010001b.
`default_nettype none

module rtcb_timekeeping
    import rtcb_pkg::*;
#(
    parameter int unsigned FAIL_CYCLES = FAIL_CYC
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic osc_clk_i,
    input wire logic backup_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic sec_tick_o,
    output logic osc_halt_o,
    output logic osc_fail_o
);

    // Steps a two-digit BCD value; invalid digits just keep stepping.
    function automatic logic [7:0] bcd_next(input logic [7:0] v,
        input logic [7:0] last, input logic [7:0] first,
        input logic [3:0] tmask);
        logic [3:0] u;
        logic [3:0] t;
        u = v[3:0];
        t = v[7:4];
        if (v == last) begin
            bcd_next = first;
        end else if (u == 4'h9 || u == 4'hf) begin
            // The tens field wraps within its own width.
            bcd_next = {(t + 4'h1) & tmask, 4'h0};
        end else begin
            bcd_next = {t, u + 4'h1};
        end
    endfunction : bcd_next

    // Last date of a month in BCD, for a BCD month and BCD year.
    function automatic logic [7:0] month_end(input logic [4:0] m,
        input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 ||
                       y[3:0] == 4'h8);
        case (m)
            5'h02: month_end = leap ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: month_end = 8'h30;
            default: month_end = 8'h31;
        endcase
    endfunction : month_end

    // Live counters; each holds only its defined bits.
    logic [7:0] sec_q; // Halt bit plus seconds.
    logic [7:0] min_q; // Fail flag plus minutes.
    logic [7:0] hour_q; // Century enable, century bit, hours.
    logic [2:0] wday_q; // Day of week.
    logic [5:0] date_q; // Day of month.
    logic [4:0] mon_q; // Month.
    logic [7:0] year_q; // Year.
    // Copy the host reads; it lags the counters after backup.
    logic [7:0] shadow_q [0:REG_COUNT-1];
    logic fresh_q; // Copy follows the counters.
    // Backup pin synchroniser and agreed level.
    logic [2:0] bk_s_q;
    logic backup_q;
    logic zero_q; // Constant low data for the open-drain pin.

    // Outputs of the helpers.
    logic tick;
    logic fail_pulse;
    logic sda_oe_n;
    logic wr;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;

    // Each sub-block freezes with the same clock enable.
    rtcb_osc_mon #(
        .FAIL_CYCLES(FAIL_CYCLES)
    ) u_osc (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .osc_clk_i(osc_clk_i),
        .halt_i(sec_q[HALT_BIT]),
        .sec_tick_o(tick),
        .fail_o(fail_pulse)
    );

    // Read data comes from the copy so a backup exit shows old time.
    wire logic in_map = (wr_addr < 8'(REG_COUNT));
    wire logic [7:0] rd_data = in_map ? shadow_q[wr_addr[2:0]] : 8'h00;

    rtcb_i2c_slave u_bus (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .refuse_i(backup_q),
        .rdata_i(rd_data),
        .sda_oe_n_o(sda_oe_n),
        .wr_o(wr),
        .addr_o(wr_addr),
        .wdata_o(wr_data)
    );

    // Write strobes per register; unmapped writes fall away.
    wire logic wr_sec = wr && (wr_addr == REG_SEC);
    wire logic wr_min = wr && (wr_addr == REG_MIN);
    wire logic wr_hour = wr && (wr_addr == REG_HOUR);
    wire logic wr_wday = wr && (wr_addr == REG_WDAY);
    wire logic wr_date = wr && (wr_addr == REG_DATE);
    wire logic wr_mon = wr && (wr_addr == REG_MON);
    wire logic wr_year = wr && (wr_addr == REG_YEAR);

    // Carry chain; each carry needs the field at its last value.
    wire logic [7:0] date_last = month_end(mon_q, year_q);
    wire logic c_sec = tick && (sec_q[6:0] == SEC_LAST[6:0]);
    wire logic c_min = c_sec && (min_q[6:0] == MIN_LAST[6:0]);
    wire logic c_hour = c_min && (hour_q[5:0] == HOUR_LAST[5:0]);
    wire logic c_date = c_hour && ({2'b00, date_q} == date_last);
    wire logic c_mon = c_date && ({3'b000, mon_q} == MON_LAST);
    wire logic c_year = c_mon && (year_q == YEAR_LAST);

    // Stepped values of each field.
    wire logic [7:0] sec_inc = bcd_next({1'b0, sec_q[6:0]}, SEC_LAST,
        8'h00, 4'h7);
    wire logic [7:0] min_inc = bcd_next({1'b0, min_q[6:0]}, MIN_LAST,
        8'h00, 4'h7);
    wire logic [7:0] hour_inc = bcd_next({2'b00, hour_q[5:0]},
        HOUR_LAST, 8'h00, 4'h3);
    wire logic [7:0] date_inc = bcd_next({2'b00, date_q}, date_last,
        8'h01, 4'h3);
    wire logic [7:0] mon_inc = bcd_next({3'b000, mon_q}, MON_LAST,
        8'h01, 4'h1);
    wire logic [7:0] year_inc = bcd_next(year_q, YEAR_LAST, 8'h00,
        4'hf);
    // Zero or seven both lead back to Sunday.
    wire logic [2:0] wday_inc = (wday_q == WDAY_LAST || wday_q == 3'h0)
        ? 3'h1 : wday_q + 3'h1;

    // Next values; a host write to a register beats its own step.
    // Reserved bits are never stored, so a careless host is harmless.
    wire logic [7:0] sec_d = wr_sec ? wr_data
        : c_sec ? {sec_q[7], 7'h00}
        : tick ? {sec_q[7], sec_inc[6:0]} : sec_q;
    wire logic [6:0] min_cnt = c_min ? 7'h00
        : c_sec ? min_inc[6:0] : min_q[6:0];
    // The fail event wins over a host clear in the same cycle.
    wire logic fail_d = (wr_min ? wr_data[FAIL_BIT] : min_q[FAIL_BIT])
        | fail_pulse;
    wire logic [7:0] min_d = {fail_d, wr_min ? wr_data[6:0] : min_cnt};
    // The century bit flips only with tracking on.
    wire logic hundred_year_flag_d = hour_q[HUNDRED_YEAR_FLAG_BIT] ^
        (c_year & hour_q[HUNDRED_YEAR_TRACK_ENABLE_BIT]);
    wire logic [5:0] hour_cnt = c_hour ? 6'h00
        : c_min ? hour_inc[5:0] : hour_q[5:0];
    wire logic [7:0] hour_d = wr_hour ? wr_data
        : {hour_q[HUNDRED_YEAR_TRACK_ENABLE_BIT], hundred_year_flag_d, hour_cnt};
    wire logic [2:0] wday_d = wr_wday ? wr_data[2:0]
        : c_hour ? wday_inc : wday_q;
    wire logic [5:0] date_d = wr_date ? wr_data[5:0]
        : c_hour ? date_inc[5:0] : date_q;
    wire logic [4:0] mon_d = wr_mon ? wr_data[4:0]
        : c_date ? mon_inc[4:0] : mon_q;
    wire logic [7:0] year_d = wr_year ? wr_data
        : c_mon ? year_inc : year_q;

    // Bytes as the host sees them; reserved bits read as zero.
    wire logic [7:0] live_w [0:REG_COUNT-1];
    assign live_w[0] = sec_q;
    assign live_w[1] = min_q;
    assign live_w[2] = hour_q;
    assign live_w[3] = {5'h00, wday_q};
    assign live_w[4] = {2'b00, date_q};
    assign live_w[5] = {3'b000, mon_q};
    assign live_w[6] = year_q;

    // Backup pin synchroniser; only stages two and three are compared.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            bk_s_q <= 3'h0;
            backup_q <= 1'b0;
        end else if (ce_i) begin
            bk_s_q <= {bk_s_q[1:0], backup_i};
            if (bk_s_q[1] == bk_s_q[2]) begin
                backup_q <= bk_s_q[2];
            end
        end
    end

    // Counter bank; reset stands for the very first power-up.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sec_q <= SEC_RST;
            min_q <= MIN_RST;
            hour_q <= HOUR_RST;
            wday_q <= WDAY_RST;
            date_q <= DATE_RST;
            mon_q <= MON_RST;
            year_q <= YEAR_RST;
        end else if (ce_i) begin
            sec_q <= sec_d;
            min_q <= min_d;
            hour_q <= hour_d;
            wday_q <= wday_d;
            date_q <= date_d;
            mon_q <= mon_d;
            year_q <= year_d;
        end
    end

    // Read copy: frozen in backup and held after it until the next
    // second tick, so the host may see the old time for a second.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            fresh_q <= 1'b1;
            for (int k = 0; k < REG_COUNT; k++) begin
                shadow_q[k] <= 8'h00;
            end
        end else if (ce_i) begin
            if (backup_q) begin
                fresh_q <= 1'b0;
            end else if (tick) begin
                fresh_q <= 1'b1;
            end
            if (fresh_q && !backup_q) begin
                for (int k = 0; k < REG_COUNT; k++) begin
                    shadow_q[k] <= live_w[k];
                end
            end
        end
    end

    // Registered top-level outputs.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            zero_q <= 1'b0;
            sda_o <= 1'b0;
            sda_oe_n_o <= 1'b1;
            sec_tick_o <= 1'b0;
            osc_halt_o <= 1'b0;
            osc_fail_o <= 1'b1;
        end else if (ce_i) begin
            zero_q <= 1'b0;
            sda_o <= zero_q;
            sda_oe_n_o <= sda_oe_n;
            sec_tick_o <= tick;
            osc_halt_o <= sec_q[HALT_BIT];
            osc_fail_o <= min_q[FAIL_BIT];
        end
    end

endmodule : rtcb_timekeeping

`default_nettype wire

/* File: hw/rtcb_pkg.sv */
// Shared constants for the BCD calendar and time counter bank.
// Assumes a 100 MHz system clock and a 32.768 kHz oscillator input.
`default_nettype none

package rtcb_pkg;

    // System clock and oscillator rates in hertz.
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned OSC_FREQ_HZ = 32768;

    // Oscillator edges per second; the prescaler wraps at the last one.
    localparam logic [14:0] TICK_LAST = 15'h7fff;

    // Missed pulses before the fail flag latches, and the silent time
    // that proves it: one period more than the misses, rounded down.
    localparam int unsigned OSC_MISS_PULSES = 4;
    localparam int unsigned FAIL_CYC =
        ((OSC_MISS_PULSES + 1) * CLK_HZ) / OSC_FREQ_HZ;

    // Serial slave address, seven bits, write and read share it.
    localparam logic [6:0] BUS_ADDR = 7'h68;

    // Register offsets on the serial bus.
    localparam logic [7:0] REG_SEC = 8'h00;
    localparam logic [7:0] REG_MIN = 8'h01;
    localparam logic [7:0] REG_HOUR = 8'h02;
    localparam logic [7:0] REG_WDAY = 8'h03;
    localparam logic [7:0] REG_DATE = 8'h04;
    localparam logic [7:0] REG_MON = 8'h05;
    localparam logic [7:0] REG_YEAR = 8'h06;
    localparam int unsigned REG_COUNT = 7;

    // Control and flag bit positions.
    localparam int unsigned HALT_BIT = 7;
    localparam int unsigned FAIL_BIT = 7;
    localparam int unsigned HUNDRED_YEAR_TRACK_ENABLE_BIT = 7;
    localparam int unsigned HUNDRED_YEAR_FLAG_BIT = 6;

    // Values after first power-up.
    localparam logic [7:0] SEC_RST = 8'h00;
    localparam logic [7:0] MIN_RST = 8'h80;
    localparam logic [7:0] HOUR_RST = 8'h00;
    localparam logic [2:0] WDAY_RST = 3'h1;
    localparam logic [5:0] DATE_RST = 6'h01;
    localparam logic [4:0] MON_RST = 5'h01;
    localparam logic [7:0] YEAR_RST = 8'h00;

    // Last valid BCD value of each field but the date before it rolls over.
    localparam logic [7:0] SEC_LAST = 8'h59;
    localparam logic [7:0] MIN_LAST = 8'h59;
    localparam logic [7:0] HOUR_LAST = 8'h23;
    localparam logic [2:0] WDAY_LAST = 3'h7;
    localparam logic [7:0] MON_LAST = 8'h12;
    localparam logic [7:0] YEAR_LAST = 8'h99;

endpackage : rtcb_pkg

`default_nettype wire

/* File: hw/rtcb_osc_mon.sv */
// Oscillator watcher: second prescaler and miss detector.
// Assumes the oscillator input is asynchronous to clk_i.
`default_nettype none

module rtcb_osc_mon
    import rtcb_pkg::*;
#(
    parameter int unsigned FAIL_CYCLES = FAIL_CYC
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic osc_clk_i,
    input wire logic halt_i,
    output logic sec_tick_o,
    output logic fail_o
);

    // Three-stage synchroniser; only stages two and three are compared.
    logic s1_q, s2_q, s3_q;
    // Last agreed level of the oscillator.
    logic lvl_q;
    // Prescaler of oscillator edges.
    logic [14:0] div_q;
    // Clock cycles since the last accepted oscillator edge.
    logic [15:0] gap_q;

    // A rise counts once stages two and three agree on high.
    wire logic agree = (s2_q == s3_q);
    wire logic rise = agree & s3_q & ~lvl_q;
    // A halted oscillator produces no edges at all.
    wire logic edge_ok = rise & ~halt_i;
    wire logic gap_end = (gap_q == 16'(FAIL_CYCLES - 1));

    // Synchroniser, prescaler and silence counter.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
            div_q <= 15'h0000;
            gap_q <= 16'h0000;
            sec_tick_o <= 1'b0;
            fail_o <= 1'b0;
        end else if (ce_i) begin
            s1_q <= osc_clk_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree) begin
                lvl_q <= s3_q;
            end
            sec_tick_o <= edge_ok && (div_q == TICK_LAST);
            if (edge_ok) begin
                div_q <= div_q + 15'h0001;
            end
            // The counter stops at the limit so the flag pulses once.
            fail_o <= !edge_ok && gap_end;
            if (edge_ok) begin
                gap_q <= 16'h0000;
            end else if (!gap_end && gap_q != 16'(FAIL_CYCLES)) begin
                gap_q <= gap_q + 16'h0001;
            end else begin
                gap_q <= 16'(FAIL_CYCLES);
            end
        end
    end

endmodule : rtcb_osc_mon

`default_nettype wire

/* File: hw/rtcb_i2c_slave.sv */
// Serial two-wire slave: address match, pointer, byte transfers.
// Assumes SCL and SDA come from pins, asynchronous to clk_i.
`default_nettype none

module rtcb_i2c_slave
    import rtcb_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic refuse_i,
    input wire logic [7:0] rdata_i,
    output logic sda_oe_n_o,
    output logic wr_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o
);

    typedef enum {ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD,
        ST_RACK} rtcb_i2c_e;

    rtcb_i2c_e st_q;
    // Synchronisers and agreed levels.
    logic [2:0] scl_s_q, sda_s_q;
    logic scl_q, sda_q;
    logic [7:0] sh_q; // Shift register for both directions.
    logic [3:0] cnt_q; // Bits moved in the current byte.
    logic rw_q; // Direction from the address byte.
    logic first_q; // Next written byte sets the pointer.
    logic ack_q; // Master acknowledged a read byte.

    wire logic scl_ok = (scl_s_q[1] == scl_s_q[2]);
    wire logic sda_ok = (sda_s_q[1] == sda_s_q[2]);
    wire logic scl_rise = scl_ok & scl_s_q[2] & ~scl_q;
    wire logic scl_fall = scl_ok & ~scl_s_q[2] & scl_q;
    wire logic sda_new = sda_ok ? sda_s_q[2] : sda_q;
    wire logic start = scl_q & scl_ok & scl_s_q[2] & sda_q & ~sda_new;
    wire logic stop = scl_q & scl_ok & scl_s_q[2] & ~sda_q & sda_new;
    wire logic addr_hit = (sh_q[7:1] == BUS_ADDR) && !refuse_i;

    // Bus protocol engine; SDA changes only after SCL falls.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_q <= ST_IDLE;
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            ack_q <= 1'b0;
            sda_oe_n_o <= 1'b1;
            wr_o <= 1'b0;
            addr_o <= 8'h00;
            wdata_o <= 8'h00;
        end else if (ce_i) begin
            scl_s_q <= {scl_s_q[1:0], scl_i};
            sda_s_q <= {sda_s_q[1:0], sda_i};
            if (scl_ok) begin
                scl_q <= scl_s_q[2];
            end
            sda_q <= sda_new;
            wr_o <= 1'b0;
            if (stop) begin
                st_q <= ST_IDLE;
                sda_oe_n_o <= 1'b1;
            end else if (start) begin
                st_q <= ST_ADDR;
                cnt_q <= 4'h0;
                first_q <= 1'b1;
                sda_oe_n_o <= 1'b1;
            end else if (scl_rise) begin
                if (st_q == ST_ADDR || st_q == ST_WR) begin
                    sh_q <= {sh_q[6:0], sda_q};
                    cnt_q <= cnt_q + 4'h1;
                end else if (st_q == ST_RACK) begin
                    ack_q <= ~sda_q;
                end
            end else if (scl_fall) begin
                case (st_q)
                    ST_ADDR: begin
                        // Backup mode answers no address at all.
                        if (cnt_q == 4'h8) begin
                            if (addr_hit) begin
                                st_q <= ST_AACK;
                                rw_q <= sh_q[0];
                                sda_oe_n_o <= 1'b0;
                            end else begin
                                st_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK: begin
                        cnt_q <= 4'h0;
                        if (rw_q) begin
                            st_q <= ST_RD;
                            sh_q <= {rdata_i[6:0], 1'b0};
                            sda_oe_n_o <= rdata_i[7];
                        end else begin
                            st_q <= ST_WR;
                            sda_oe_n_o <= 1'b1;
                        end
                    end
                    ST_WR: begin
                        // Only a whole byte is committed.
                        if (cnt_q == 4'h8) begin
                            st_q <= ST_WACK;
                            sda_oe_n_o <= 1'b0;
                            if (first_q) begin
                                addr_o <= sh_q;
                            end else begin
                                wr_o <= 1'b1;
                                wdata_o <= sh_q;
                            end
                        end
                    end
                    ST_WACK: begin
                        st_q <= ST_WR;
                        cnt_q <= 4'h0;
                        sda_oe_n_o <= 1'b1;
                        first_q <= 1'b0;
                        if (!first_q) begin
                            addr_o <= addr_o + 8'h01;
                        end
                    end
                    ST_RD: begin
                        if (cnt_q == 4'h7) begin
                            st_q <= ST_RACK;
                            sda_oe_n_o <= 1'b1;
                            addr_o <= addr_o + 8'h01;
                        end else begin
                            cnt_q <= cnt_q + 4'h1;
                            sda_oe_n_o <= sh_q[7];
                            sh_q <= {sh_q[6:0], 1'b0};
                        end
                    end
                    ST_RACK: begin
                        // A missing acknowledge ends the read.
                        if (ack_q) begin
                            st_q <= ST_RD;
                            cnt_q <= 4'h0;
                            sh_q <= {rdata_i[6:0], 1'b0};
                            sda_oe_n_o <= rdata_i[7];
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                    default: begin
                        st_q <= ST_IDLE;
                        sda_oe_n_o <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule : rtcb_i2c_slave

`default_nettype wire

/* File: test/rtcb_timekeeping_props.sv */
// Checker for the timekeeping bank's top-level ports.
// Assumes ce_i stays high; bound at the foot of this file.
`default_nettype none
module rtcb_timekeeping_props #(
    parameter int unsigned FAIL_CYCLES = 40
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic osc_clk_i,
    input wire logic backup_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    input wire logic sec_tick_o,
    input wire logic osc_halt_o,
    input wire logic osc_fail_o
);
    // Saturating counts of halt and backup cycles.
    logic [15:0] halt_n_q;
    logic [15:0] bkup_n_q;
    always_ff @(posedge clk_i) begin
        halt_n_q <= osc_halt_o ? halt_n_q + 16'(~&halt_n_q) : 16'h0;
        bkup_n_q <= backup_i ? bkup_n_q + 16'(~&bkup_n_q) : 16'h0;
    end
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    AST_OD_LOW: assert property (!sda_oe_n_o |-> !sda_o)
        else $error("data driven high");
    AST_ACK_SCL: assert property ($fell(sda_oe_n_o) |-> !scl_i)
        else $error("data moved while clock high");
    AST_RST_STATE: assert property (disable iff (1'b0)
        !resetn_i ##1 !resetn_i |=> osc_fail_o && !osc_halt_o
        && sda_oe_n_o && !sec_tick_o) else $error("bad reset state");
    AST_FAIL_SET: assert property (
        halt_n_q == 16'(FAIL_CYCLES + 8) |-> osc_fail_o)
        else $error("fail flag not set");
    AST_HALT_TICK: assert property (
        halt_n_q > 16'h4 |-> !sec_tick_o) else $error("tick while halted");
    AST_TICK_PULSE: assert property (
        sec_tick_o |=> !sec_tick_o [*8]) else $error("tick too long");
    AST_BKUP_REFUSE: assert property (
        bkup_n_q > 16'h8 |-> sda_oe_n_o) else $error("answer during backup");
    AST_FAIL_CLR: assert property ($fell(osc_fail_o) |-> !scl_i)
        else $error("fail flag cleared outside a write");
    AST_HALT_WR: assert property ($changed(osc_halt_o) |-> !scl_i)
        else $error("halt changed outside a write");
endmodule : rtcb_timekeeping_props
bind rtcb_timekeeping rtcb_timekeeping_props #(
    .FAIL_CYCLES(FAIL_CYCLES)
) u_props (.*);
`default_nettype wire

/* File: test/rtcb_host.sv */
// Host model: a two-wire bus master.
// Assumes the bench pulls the data line up.
`default_nettype none
module rtcb_host (
    input wire logic clk_i,
    input wire logic sda_i,
    output var logic scl_o,
    output var logic sda_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF = 12;
    // Both lines idle high.
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // One phase: change after an edge, then hold.
    task automatic step(input logic s, input logic d);
        @(posedge clk_i);
        scl_o <= s;
        sda_o <= d;
        repeat (HALF) @(posedge clk_i);
    endtask : step
    // Start (d=0) or stop (d=1).
    task automatic cond(input logic d);
        step(1'b0, sda_o);
        step(1'b0, ~d);
        step(1'b1, ~d);
        step(1'b1, d);
    endtask : cond
    // Nine bits MSB first; data moves while clock is low.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                        output logic a);
        for (int i = 8; i >= 0; i--) begin
            step(1'b0, sda_o);
            step(1'b0, (i == 0) ? 1'b1 : tx[i-1]);
            step(1'b1, sda_o);
            if (i == 0) begin
                a = sda_i;
            end else begin
                rx[i-1] = sda_i;
            end
        end
    endtask : xfer
    // Caller keeps reserved bits zero; digits may be invalid.
    task automatic wr(input logic [7:0] dev, input logic [7:0] p,
                      input logic [7:0] d, output logic nak);
        logic [7:0] x;
        logic a0, a1, a2;
        cond(1'b0);
        xfer(dev, x, a0);
        xfer(p, x, a1);
        xfer(d, x, a2);
        cond(1'b1);
        nak = a0 | a1 | a2;
    endtask : wr
    // Pointer, repeated start, one byte, then refusal.
    task automatic rd(input logic [7:0] dev, input logic [7:0] p,
                      output logic [7:0] d, output logic nak);
        logic [7:0] x;
        logic a0, a1, a2, a3;
        cond(1'b0);
        xfer(dev, x, a0);
        xfer(p, x, a1);
        cond(1'b0);
        xfer(dev | 8'h01, x, a2);
        xfer(8'hff, d, a3);
        cond(1'b1);
        nak = a0 | a1 | a2;
    endtask : rd
endmodule : rtcb_host
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the timekeeping bank.
// Assumes the host model and checker compile first.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned FAILN = 40;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic osc = 1'b0;
    logic backup = 1'b0;
    logic scl, h_sda, sda_o, sda_oe_n, tick, halt, fail, ack;
    logic [7:0] rv;
    int failures = 0;
    int checks_done = 0;
    wire logic sda_w;
    // Open drain with a pull-up.
    assign sda_w = h_sda & (sda_oe_n | sda_o);
    initial forever #5 clk_i = ~clk_i;
    // Oscillator, 160 ns period, own phase.
    initial begin
        #3;
        forever #80 osc = ~osc;
    end
    rtcb_timekeeping #(.FAIL_CYCLES(FAILN)) u_dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
        .osc_clk_i(osc), .backup_i(backup), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .sec_tick_o(tick),
        .osc_halt_o(halt), .osc_fail_o(fail));
    rtcb_host u_host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl),
        .sda_o(h_sda));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic stop_test();
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    // Power-up values of all registers.
    task automatic t_reset();
        logic [7:0] e [7] = '{8'h00, 8'h80, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
        for (int i = 0; i < 7; i++) begin
            u_host.rd(8'hd0, 8'(i), rv, ack);
            check(rv, e[i]);
            check(8'(ack), 8'h00);
        end
    endtask : t_reset
    // Invalid digits stay as written; fail flag clears.
    task automatic t_rw();
        logic [7:0] v [7] = '{8'h59, 8'h7a, 8'he3, 8'h07, 8'h31, 8'h12, 8'h99};
        for (int i = 0; i < 7; i++) begin
            u_host.wr(8'hd0, 8'(i), v[i], ack);
        end
        for (int i = 0; i < 7; i++) begin
            u_host.rd(8'hd0, 8'(i), rv, ack);
            check(rv, v[i]);
        end
        check(8'(fail), 8'h00);
    endtask : t_rw
    // Foreign address and backup go unanswered.
    task automatic t_refuse();
        u_host.wr(8'hd2, 8'h00, 8'h00, ack);
        check(8'(ack), 8'h01);
        @(posedge clk_i) backup <= 1'b1;
        repeat (10) @(posedge clk_i);
        u_host.wr(8'hd0, 8'h06, 8'h00, ack);
        check(8'(ack), 8'h01);
        @(posedge clk_i) backup <= 1'b0;
        repeat (6000) @(posedge clk_i);
        u_host.rd(8'hd0, 8'h06, rv, ack);
        check(rv, 8'h99);
    endtask : t_refuse
    // Halting starves the fail detector.
    task automatic t_halt();
        u_host.wr(8'hd0, 8'h00, 8'h80, ack);
        check(8'(halt), 8'h01);
        repeat (FAILN + 20) @(posedge clk_i);
        check(8'(fail), 8'h01);
        check(8'(tick), 8'h00);
        u_host.wr(8'hd0, 8'h00, 8'h00, ack);
        check(8'(halt), 8'h00);
    endtask : t_halt
    initial begin
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        t_reset();
        t_rw();
        t_refuse();
        t_halt();
        stop_test();
    end
    // A hang counts as a failure.
    initial begin
        repeat (60000) @(posedge clk_i);
        failures++;
        stop_test();
    end
endmodule : tb
`default_nettype wire
